// ### logic/dpr_host_consts.svh
// Constants for the processor-side controller of one dual-port RAM port.
// Assumes a 40 MHz controller clock and the slowest device grade.
`ifndef DPR_HOST_CONSTS_SVH
`define DPR_HOST_CONSTS_SVH

`define DPR_ADDR_W        11
`define DPR_DATA_W        8
`define DPR_MAIL_LEFT     11'h7fe
`define DPR_MAIL_RIGHT    11'h7ff

`define DPR_CLK_NS        25
`define DPR_SYNC_STAGES   2
// Contention output valid after address/enable settle
`define DPR_SETTLE_NS     30
`define DPR_SETTLE_CYC    ((`DPR_SETTLE_NS + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
// Contention release to valid data
`define DPR_RELEASE_NS    50
`define DPR_RELEASE_CYC   ((`DPR_RELEASE_NS + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
// Read access and write pulse length
`define DPR_ACCESS_NS     55
`define DPR_ACCESS_CYC    ((`DPR_ACCESS_NS + `DPR_CLK_NS - 1) / `DPR_CLK_NS)

`endif

// ### logic/dpr_host_pkg.sv
// Types shared by the dual-port RAM port controller.
// Assumes dpr_host_consts.svh on the include path.
`include "dpr_host_consts.svh"

package dpr_host_pkg;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_SEND_MAIL,
        OP_TAKE_MAIL
    } op_type;

    typedef struct packed {
        op_type                    op;
        logic [`DPR_ADDR_W-1:0]    addr;
        logic [`DPR_DATA_W-1:0]    wdata;
    } cmd_type;

    typedef struct packed {
        logic [`DPR_DATA_W-1:0]    rdata;
        logic                      collided;
    } rsp_type;

endpackage

// ### logic/dpr_port_master.sv
// Processor-side controller for one port of a 2K x 8 dual-port RAM with
// mailbox interrupts and contention arbitration.
// Assumes the RAM pins are asynchronous to CLK; the data bus wire is
// resolved outside from RAM_DATA_OUT and RAM_DATA_OE_N.
//
// What this block does
// - Read data untrusted until contention clears, propagates
// - Right reads 7FF with enables low, clears
// - Left reads 7FE with enables low, clears
// - Without interrupts, mailboxes are plain storage
`timescale 1ns/10ps

module dpr_port_master
    import dpr_host_pkg::*;
#(
    parameter bit LEFT_SIDE  = 1'b1,
    parameter bit MAILBOX_EN = 1'b1
) (
    input  wire logic                   CLK,            // 40 MHz clock
    input  wire logic                   RESET_N,        // Async reset
    input  wire logic                   CMD_VALID,      // Command offered
    input  wire cmd_type                CMD,            // Command
    output logic                        CMD_READY,      // Command taken
    output logic                        RSP_VALID,      // Result pulse
    output rsp_type                     RSP,            // Result
    output logic                        MAIL_PENDING,   // Mail waiting
    output logic                        RAM_CE_N,       // Chip enable
    output logic                        RAM_RW_N,       // Read/write
    output logic                        RAM_OE_N,       // Output enable
    output logic [`DPR_ADDR_W-1:0]      RAM_ADDR,       // Address
    input  wire logic [`DPR_DATA_W-1:0] RAM_DATA_IN,    // Data pin level
    output logic [`DPR_DATA_W-1:0]      RAM_DATA_OUT,   // Data to drive
    output logic                        RAM_DATA_OE_N,  // Low: drive data
    input  wire logic                   RAM_CONTENTION_N, // Contention pin
    input  wire logic                   RAM_IRQ_N       // Mailbox irq pin
);

    localparam logic [3:0] SETTLE_CYC =
        4'(`DPR_SETTLE_CYC + `DPR_SYNC_STAGES);
    localparam logic [3:0] RELEASE_CYC =
        4'(`DPR_RELEASE_CYC + `DPR_SYNC_STAGES);
    localparam logic [3:0] ACCESS_CYC =
        4'(`DPR_ACCESS_CYC + `DPR_SYNC_STAGES);
    localparam logic [`DPR_ADDR_W-1:0] OWN_MAIL =
        LEFT_SIDE ? `DPR_MAIL_LEFT : `DPR_MAIL_RIGHT;
    localparam logic [`DPR_ADDR_W-1:0] PEER_MAIL =
        LEFT_SIDE ? `DPR_MAIL_RIGHT : `DPR_MAIL_LEFT;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_ACCESS,
        ST_HOLD
    } state_type;

    // Reset release
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // Pin inputs, synchronised
    logic [`DPR_DATA_W+1:0] pins_sync;
    logic [`DPR_DATA_W-1:0] data_sync;
    logic                   contention_n_sync;
    logic                   irq_n_sync;

    dpr_sync2 #(
        .WIDTH (`DPR_DATA_W + 2)
    ) pin_sync (
        .clk   (CLK),
        .rst_n (rst_n_reg),
        .d     ({RAM_DATA_IN, RAM_CONTENTION_N, RAM_IRQ_N}),
        .q     (pins_sync)
    );

    assign data_sync         = pins_sync[`DPR_DATA_W+1:2];
    assign contention_n_sync = pins_sync[1];
    assign irq_n_sync        = pins_sync[0];

    state_type              state_reg,    state_next;
    logic [3:0]             cnt_reg,      cnt_next;
    logic                   is_write_reg, is_write_next;
    logic                   collided_reg, collided_next;
    logic                   ready_reg,    ready_next;
    logic                   rsp_valid_reg, rsp_valid_next;
    logic [`DPR_DATA_W-1:0] rdata_reg,    rdata_next;
    logic                   mail_reg,     mail_next;
    logic                   ce_n_reg,     ce_n_next;
    logic                   rw_n_reg,     rw_n_next;
    logic                   oe_n_reg,     oe_n_next;
    logic                   dq_oe_n_reg,  dq_oe_n_next;
    logic [`DPR_ADDR_W-1:0] addr_reg,     addr_next;
    logic [`DPR_DATA_W-1:0] dout_reg,     dout_next;

    always_comb begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        is_write_next  = is_write_reg;
        collided_next  = collided_reg;
        ready_next     = ready_reg;
        rsp_valid_next = 1'b0;
        rdata_next     = rdata_reg;
        ce_n_next      = ce_n_reg;
        rw_n_next      = rw_n_reg;
        oe_n_next      = oe_n_reg;
        dq_oe_n_next   = dq_oe_n_reg;
        addr_next      = addr_reg;
        dout_next      = dout_reg;
        // Interrupt level held by the device until our clearing read
        mail_next      = MAILBOX_EN & ~irq_n_sync;
        case (state_reg)
            ST_IDLE: begin
                if (CMD_VALID && ready_reg) begin
                    ready_next    = 1'b0;
                    collided_next = 1'b0;
                    dout_next     = CMD.wdata;
                    is_write_next = (CMD.op == OP_WRITE) ||
                                    (CMD.op == OP_SEND_MAIL);
                    case (CMD.op)
                        OP_SEND_MAIL: addr_next = PEER_MAIL;
                        OP_TAKE_MAIL: addr_next = OWN_MAIL;
                        default:      addr_next = CMD.addr;
                    endcase
                    // Address and enable first: arbitration sees only these
                    ce_n_next  = 1'b0;
                    cnt_next   = SETTLE_CYC;
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (!contention_n_sync) begin
                    // We lost arbitration: hold the access, then wait for
                    // the winner's data to propagate before continuing
                    collided_next = 1'b1;
                    cnt_next      = RELEASE_CYC;
                end else if (cnt_reg != 4'h0) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    // Write strobe only once contention is known clear, so
                    // no write is lost to internal suppression
                    cnt_next   = ACCESS_CYC;
                    state_next = ST_ACCESS;
                    if (is_write_reg) begin
                        rw_n_next    = 1'b0;
                        dq_oe_n_next = 1'b0;
                    end else begin
                        oe_n_next = 1'b0;
                    end
                end
            end
            ST_ACCESS: begin
                if (cnt_reg != 4'h0) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    if (!is_write_reg) begin
                        rdata_next = data_sync;
                    end
                    rw_n_next  = 1'b1;
                    oe_n_next  = 1'b1;
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Data held one cycle past the write strobe's rise
                dq_oe_n_next   = 1'b1;
                ce_n_next      = 1'b1;
                rsp_valid_next = 1'b1;
                ready_next     = 1'b1;
                state_next     = ST_IDLE;
            end
            default: begin
                state_next   = ST_IDLE;
                ce_n_next    = 1'b1;
                rw_n_next    = 1'b1;
                oe_n_next    = 1'b1;
                dq_oe_n_next = 1'b1;
                ready_next   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= 4'h0;
            is_write_reg  <= 1'b0;
            collided_reg  <= 1'b0;
            ready_reg     <= 1'b1;
            rsp_valid_reg <= 1'b0;
            rdata_reg     <= 8'h00;
            mail_reg      <= 1'b0;
            ce_n_reg      <= 1'b1;
            rw_n_reg      <= 1'b1;
            oe_n_reg      <= 1'b1;
            dq_oe_n_reg   <= 1'b1;
            addr_reg      <= 11'h000;
            dout_reg      <= 8'h00;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            is_write_reg  <= is_write_next;
            collided_reg  <= collided_next;
            ready_reg     <= ready_next;
            rsp_valid_reg <= rsp_valid_next;
            rdata_reg     <= rdata_next;
            mail_reg      <= mail_next;
            ce_n_reg      <= ce_n_next;
            rw_n_reg      <= rw_n_next;
            oe_n_reg      <= oe_n_next;
            dq_oe_n_reg   <= dq_oe_n_next;
            addr_reg      <= addr_next;
            dout_reg      <= dout_next;
        end
    end

    assign CMD_READY     = ready_reg;
    assign RSP_VALID     = rsp_valid_reg;
    assign RSP           = '{rdata: rdata_reg, collided: collided_reg};
    assign MAIL_PENDING  = mail_reg;
    assign RAM_CE_N      = ce_n_reg;
    assign RAM_RW_N      = rw_n_reg;
    assign RAM_OE_N      = oe_n_reg;
    assign RAM_ADDR      = addr_reg;
    assign RAM_DATA_OUT  = dout_reg;
    assign RAM_DATA_OE_N = dq_oe_n_reg;

endmodule

// ### logic/dpr_sync2.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the inputs change asynchronously to clk; resets to all ones.
`timescale 1ns/10ps

module dpr_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,    // Controller clock
    input  wire logic             rst_n,  // Active-low reset
    input  wire logic [WIDTH-1:0] d,      // Asynchronous levels
    output logic      [WIDTH-1:0] q       // Synchronised levels
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    always_comb begin
        meta_next = d;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '1;
            q_reg    <= '1;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q = q_reg;

endmodule

// ### tb/dpr_port_master_chk_sva.sv
// Checker for the dual-port RAM port controller, bound to its pins.
// Assumes the controller runs with the mailbox enabled.
`timescale 1ns/10ps
`include "dpr_host_consts.svh"
module dpr_port_master_chk (
    input wire logic                   CLK,              // Clock
    input wire logic                   RESET_N,          // Reset
    input wire logic                   CMD_VALID,        // Offered
    input wire logic                   CMD_READY,        // Idle
    input wire logic                   RSP_VALID,        // Done
    input wire logic                   MAIL_PENDING,     // Mail flag
    input wire logic                   RAM_CE_N,         // Enable
    input wire logic                   RAM_RW_N,         // Strobe
    input wire logic                   RAM_OE_N,         // Output enable
    input wire logic [`DPR_ADDR_W-1:0] RAM_ADDR,         // Address
    input wire logic                   RAM_DATA_OE_N,    // Drive data
    input wire logic                   RAM_CONTENTION_N, // Contention
    input wire logic                   RAM_IRQ_N         // Mailbox irq
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    chk_idle_float: assert property (
        RAM_CE_N |-> RAM_DATA_OE_N) else $error("data driven while idle");
    chk_write_len: assert property (
        $fell(RAM_RW_N) |-> !RAM_CE_N && !RAM_DATA_OE_N ##0
        !RAM_RW_N [*6] ##1 RAM_RW_N) else $error("bad write strobe");
    chk_read_len: assert property (
        $fell(RAM_OE_N) |-> RAM_RW_N && RAM_DATA_OE_N ##0
        !RAM_OE_N [*6] ##1 RAM_OE_N) else $error("bad read window");
    chk_busy_block: assert property (
        $fell(RAM_RW_N) |-> $past(RAM_CONTENTION_N, 3) &&
        $past(RAM_CONTENTION_N, 4)) else $error("write under contention");
    chk_done_pulse: assert property (
        RSP_VALID |-> RAM_CE_N && CMD_READY ##1 !RSP_VALID)
        else $error("bad completion pulse");
    chk_answer_time: assert property (
        CMD_VALID && CMD_READY |=> !CMD_READY && !RAM_CE_N ##[12:80]
        RSP_VALID) else $error("command not answered in time");
    chk_addr_hold: assert property (
        !RAM_CE_N && !$past(RAM_CE_N) |-> $stable(RAM_ADDR))
        else $error("address moved during access");
    chk_mail_set: assert property (
        !RAM_IRQ_N [*7] |-> MAIL_PENDING) else $error("mail not flagged");
    chk_mail_clear: assert property (
        RAM_IRQ_N [*7] |-> !MAIL_PENDING) else $error("stale mail flag");
endmodule

bind dpr_port_master dpr_port_master_chk chk (
    .CLK(CLK), .RESET_N(RESET_N), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID),
    .MAIL_PENDING(MAIL_PENDING), .RAM_CE_N(RAM_CE_N),
    .RAM_RW_N(RAM_RW_N), .RAM_OE_N(RAM_OE_N), .RAM_ADDR(RAM_ADDR),
    .RAM_DATA_OE_N(RAM_DATA_OE_N), .RAM_CONTENTION_N(RAM_CONTENTION_N),
    .RAM_IRQ_N(RAM_IRQ_N));

// ### tb/dpr_ram_model.sv
// Behavioural left port of the dual-port RAM, with the peer as stimulus.
// Assumes the bench resolves the data wire from both drivers.
`timescale 1ns/10ps
`include "dpr_host_consts.svh"
module dpr_ram_model (
    input wire logic                   ce_n,       // Chip enable
    input wire logic                   rw_n,       // Read/write
    input wire logic                   oe_n,       // Output enable
    input wire logic [`DPR_ADDR_W-1:0] addr,       // Address
    input wire logic [`DPR_DATA_W-1:0] din,        // Data wire level
    output logic     [`DPR_DATA_W-1:0] dout,       // Level offered
    output logic                       busy_n,     // Contention, pulled up
    output logic                       irq_n,      // Own mailbox flag
    output logic                       peer_irq_n, // Peer mailbox flag
    input wire logic [15:0]            busy_ns,    // Contention length
    input wire logic                   peer_set    // Peer wrote our box
);
    logic [`DPR_DATA_W-1:0] mem [0:2047];
    logic [`DPR_DATA_W-1:0] last = 8'h00;
    initial begin
        busy_n = 1'h1;
        irq_n = 1'h1;
        peer_irq_n = 1'h1;
    end
    // Released wire shows the inverse so a stale byte never passes
    always @* begin
        if (!ce_n && rw_n && !oe_n) begin
            dout = busy_n ? mem[addr] : ~mem[addr];
            last = dout;
        end else
            dout = ~last;
    end
    always @(posedge rw_n)
        if (ce_n === 1'h0 && busy_n) mem[addr] = din;
    // Only this port's flag is modelled, so both can never be low
    always @(negedge ce_n) begin
        if (busy_ns != 16'h0000) begin
            busy_n = 1'h0;
            #(busy_ns) busy_n = 1'h1;
        end
    end
    always @(posedge peer_set) irq_n = 1'h0;
    always @(negedge oe_n)
        if (!ce_n && addr == `DPR_MAIL_LEFT) irq_n = 1'h1;
    always @(negedge rw_n)
        if (!ce_n && addr == `DPR_MAIL_RIGHT) peer_irq_n = 1'h0;
endmodule

// ### tb/dual_port_ram_mailbox_arbiter_tb_top.sv
// Bench for the left-port controller against the RAM model.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
`include "dpr_host_consts.svh"
module dual_port_ram_mailbox_arbiter_tb_top;
    import dpr_host_pkg::*;
    logic clk, reset_n, cmd_valid, cmd_ready, rsp_valid, mail_pending;
    logic ce_n, rw_n, oe_n, data_oe_n, busy_n, irq_n, peer_irq_n, peer_set;
    logic [`DPR_ADDR_W-1:0] addr;
    logic [`DPR_DATA_W-1:0] data_in, data_out, m_dout;
    logic [15:0]            busy_ns;
    cmd_type                cmd;
    rsp_type                rsp, r;
    int                     n_mismatch = 0;
    int                     checked = 0;
    assign data_in = data_oe_n ? m_dout : data_out;

    dpr_port_master uut (.CLK(clk), .RESET_N(reset_n), .CMD_VALID(cmd_valid),
        .CMD(cmd), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP(rsp),
        .MAIL_PENDING(mail_pending), .RAM_CE_N(ce_n), .RAM_RW_N(rw_n),
        .RAM_OE_N(oe_n), .RAM_ADDR(addr), .RAM_DATA_IN(data_in),
        .RAM_DATA_OUT(data_out), .RAM_DATA_OE_N(data_oe_n),
        .RAM_CONTENTION_N(busy_n), .RAM_IRQ_N(irq_n));
    dpr_ram_model far (.ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n), .addr(addr),
        .din(data_in), .dout(m_dout), .busy_n(busy_n), .irq_n(irq_n),
        .peer_irq_n(peer_irq_n), .busy_ns(busy_ns), .peer_set(peer_set));

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Request held until taken; result captured at the pulse's edge
    task automatic do_cmd(input op_type op, input logic [10:0] a,
                          input logic [7:0] d);
        int i;
        @(posedge clk);
        cmd_valid <= 1'h1;
        cmd <= '{op, a, d};
        i = 0;
        do begin @(posedge clk); i++; end while (!cmd_ready && i < 40);
        cmd_valid <= 1'h0;
        i = 0;
        do begin @(posedge clk); i++; end while (rsp_valid !== 1'h1 && i < 200);
        if (i >= 200) begin
            n_mismatch++;
            stop_test();
        end
        r = rsp;
    endtask
    task automatic t_plain();
        logic [10:0] a [3] = '{11'h000, 11'h2a5, 11'h7fd};
        logic [7:0]  d [3] = '{8'h5a, 8'ha5, 8'h0f};
        for (int k = 0; k < 3; k++) do_cmd(OP_WRITE, a[k], d[k]);
        for (int k = 0; k < 3; k++) begin
            do_cmd(OP_READ, a[k], 8'h00);
            check(r.rdata, d[k]);
            check({7'h00, r.collided}, 8'h00);
        end
        check({6'h00, ce_n, data_oe_n}, 8'h03);
    endtask
    task automatic t_busy();
        busy_ns = 16'h00c8;
        do_cmd(OP_WRITE, 11'h123, 8'hc3);
        check({7'h00, r.collided}, 8'h01);
        do_cmd(OP_READ, 11'h123, 8'h00);
        check(r.rdata, 8'hc3);
        check({7'h00, r.collided}, 8'h01);
        busy_ns = 16'h0000;
    endtask
    task automatic t_mail();
        do_cmd(OP_WRITE, `DPR_MAIL_LEFT, 8'h66);
        check({6'h00, mail_pending, peer_irq_n}, 8'h01);
        peer_set <= 1'h1;
        for (int k = 0; k < 10 && mail_pending !== 1'h1; k++) @(posedge clk);
        peer_set <= 1'h0;
        do_cmd(OP_WRITE, 11'h100, 8'h11);
        check({7'h00, mail_pending}, 8'h01);
        do_cmd(OP_TAKE_MAIL, 11'h000, 8'h00);
        check(r.rdata, 8'h66);
        check({7'h00, mail_pending}, 8'h00);
        do_cmd(OP_SEND_MAIL, 11'h000, 8'h99);
        check({7'h00, peer_irq_n}, 8'h00);
        do_cmd(OP_READ, `DPR_MAIL_RIGHT, 8'h00);
        check(r.rdata, 8'h99);
    endtask

    initial begin
        reset_n = 1'h0;
        cmd_valid = 1'h0;
        cmd = '0;
        busy_ns = 16'h0000;
        peer_set = 1'h0;
        repeat (20) @(posedge clk);
        reset_n <= 1'h1;
        repeat (3) @(posedge clk);
        t_plain();
        t_busy();
        t_mail();
        stop_test();
    end
endmodule
